// ---- src/plc_pkg.sv ----
package plc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [9:0] ADDR_LOCK_CAL   = 10'h018;
  localparam logic [9:0] ADDR_SYNC_DELAY = 10'h019;
  localparam logic [9:0] ADDR_STAT_LD    = 10'h01a;

  localparam logic [7:0] RST_LOCK_CAL    = 8'h06;
  localparam logic [7:0] RST_SYNC_DELAY  = 8'h00;
  localparam logic [7:0] RST_STAT_LD     = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CAL_NOW_BIT    = 0;
  localparam int SYNC_MODE_HI   = 7;
  localparam int SYNC_MODE_LO   = 6;
  localparam int REF_DLY_HI     = 5;
  localparam int REF_DLY_LO     = 3;
  localparam int FB_DLY_HI      = 2;
  localparam int FB_DLY_LO      = 0;
  localparam int STAT_DIV_EN    = 7;
  localparam int REF_MON_THR    = 6;
  localparam int LD_SEL_HI      = 5;
  localparam int LD_SEL_LO      = 0;

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] SYNC_NONE_A = 2'h0;
  localparam logic [1:0] SYNC_ASYNC  = 2'h1;
  localparam logic [1:0] SYNC_SYNC   = 2'h2;

  localparam logic [5:0] LD_DLD      = 6'h00;
  localparam logic [5:0] LD_PCH_OD   = 6'h01;
  localparam logic [5:0] LD_NCH_OD   = 6'h02;
  localparam logic [5:0] LD_HIZ      = 6'h03;
  localparam logic [5:0] LD_CUR      = 6'h04;
  localparam logic [5:0] LD_M_GND    = 6'h20;
  localparam logic [5:0] LD_M_REF1   = 6'h21;
  localparam logic [5:0] LD_M_REF2   = 6'h22;
  localparam logic [5:0] LD_M_SEL    = 6'h23;
  localparam logic [5:0] LD_M_UNSEL  = 6'h24;
  localparam logic [5:0] LD_M_SEL_OK = 6'h25;
  localparam logic [5:0] LD_M_UNS_OK = 6'h26;

  localparam logic [1:0] DIV4_LAST   = 2'h3;

endpackage

// ---- src/plc_div4.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// divide-by-4 of a divider output pulse train
// ---------------------------------------------------------------
module plc_div4
  import plc_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // control and data
  input  wire logic enable,
  input  wire logic pulse_in,
  output logic      div_out
);

  logic [1:0] count;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= 2'h0;
    end else if (!enable) begin
      count <= 2'h0;
    end else if (pulse_in) begin
      count <= count + 2'h1;
    end
  end

  // square wave at a quarter of the pulse rate, low while disabled
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_out <= 1'b0;
    end else if (!enable) begin
      div_out <= 1'b0;
    end else if (pulse_in && count[0]) begin
      div_out <= ~div_out;
    end
  end

endmodule

// ---- src/plc_top.sv ----
`timescale 1ns/1ps
module plc_top
  import plc_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // register access from the serial control port
  input  wire logic [9:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       io_update,
  // pll status inputs
  input  wire logic       digital_lock_flag,
  input  wire logic       analog_lock_p,
  input  wire logic       analog_lock_n,
  input  wire logic       ref1_clk,
  input  wire logic       ref2_clk,
  input  wire logic       ref2_selected,
  input  wire logic       ref1_ok,
  input  wire logic       ref2_ok,
  input  wire logic       ref_div_pulse,
  input  wire logic       fb_div_pulse,
  // sync pin
  input  wire logic       sync_pin_b,
  // pll control outputs
  output logic            vco_cal_start,
  output logic      [6:0] lock_cal_cfg,
  output logic            ctr_async_rst,
  output logic            ctr_sync_rst,
  output logic      [2:0] ref_path_delay,
  output logic      [2:0] fb_path_delay,
  output logic            ref_monitor_thresh,
  // status pin
  output logic            status_ref_div4,
  output logic            status_fb_div4,
  // lock indicator pin
  output logic            lock_indicator_pin_out,
  output logic            lock_indicator_pin_oe_b,
  output logic            lock_indicator_cur_en
);

  // ---------------------------------------------------------------
  // buffer and active registers
  // ---------------------------------------------------------------
  logic [7:0] buf_lock_cal;
  logic [7:0] buf_sync_delay;
  logic [7:0] buf_stat_ld;
  logic [7:0] act_lock_cal;
  logic [7:0] act_sync_delay;
  logic [7:0] act_stat_ld;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      buf_lock_cal   <= RST_LOCK_CAL;
      buf_sync_delay <= RST_SYNC_DELAY;
      buf_stat_ld    <= RST_STAT_LD;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_LOCK_CAL:   buf_lock_cal   <= reg_wdata;
        ADDR_SYNC_DELAY: buf_sync_delay <= reg_wdata;
        ADDR_STAT_LD:    buf_stat_ld    <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // writes in the same cycle as the update land in the buffer only
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      act_lock_cal   <= RST_LOCK_CAL;
      act_sync_delay <= RST_SYNC_DELAY;
      act_stat_ld    <= RST_STAT_LD;
    end else if (io_update) begin
      act_lock_cal   <= buf_lock_cal;
      act_sync_delay <= buf_sync_delay;
      act_stat_ld    <= buf_stat_ld;
    end
  end

  // readback shows the active set, unmapped reads zero
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_LOCK_CAL:   reg_rdata <= act_lock_cal;
        ADDR_SYNC_DELAY: reg_rdata <= act_sync_delay;
        ADDR_STAT_LD:    reg_rdata <= act_stat_ld;
        default:         reg_rdata <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // vco calibration trigger
  // ---------------------------------------------------------------
  logic cal_now_prev;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cal_now_prev  <= 1'b0;
      vco_cal_start <= 1'b0;
    end else begin
      cal_now_prev  <= act_lock_cal[CAL_NOW_BIT];
      // a static one never retriggers; needs 0 then 1 committed
      vco_cal_start <= act_lock_cal[CAL_NOW_BIT] & ~cal_now_prev;
    end
  end

  // divider setting itself is kept moving by software during a run
  assign lock_cal_cfg = act_lock_cal[7:1];

  // ---------------------------------------------------------------
  // sync pin counter reset
  // ---------------------------------------------------------------
  logic sync_meta_b;
  logic sync_sync_b;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_meta_b <= 1'b1;
      sync_sync_b <= 1'b1;
    end else begin
      sync_meta_b <= sync_pin_b;
      sync_sync_b <= sync_meta_b;
    end
  end

  logic [1:0] sync_mode;
  assign sync_mode = act_sync_delay[SYNC_MODE_HI:SYNC_MODE_LO];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctr_async_rst <= 1'b0;
      ctr_sync_rst  <= 1'b0;
    end else begin
      ctr_async_rst <= (sync_mode == SYNC_ASYNC) & ~sync_sync_b;
      ctr_sync_rst  <= (sync_mode == SYNC_SYNC) & ~sync_sync_b;
    end
  end

  // ---------------------------------------------------------------
  // path delays and monitor threshold
  // ---------------------------------------------------------------
  assign ref_path_delay     = act_sync_delay[REF_DLY_HI:REF_DLY_LO];
  assign fb_path_delay      = act_sync_delay[FB_DLY_HI:FB_DLY_LO];
  assign ref_monitor_thresh = act_stat_ld[REF_MON_THR];

  // ---------------------------------------------------------------
  // status pin dividers
  // ---------------------------------------------------------------
  logic stat_div_en;
  assign stat_div_en = act_stat_ld[STAT_DIV_EN];

  plc_div4 u_ref_div4 (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .enable   (stat_div_en),
    .pulse_in (ref_div_pulse),
    .div_out  (status_ref_div4)
  );

  plc_div4 u_fb_div4 (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .enable   (stat_div_en),
    .pulse_in (fb_div_pulse),
    .div_out  (status_fb_div4)
  );

  // ---------------------------------------------------------------
  // lock indicator pin select
  // ---------------------------------------------------------------
  logic [5:0] ld_sel;
  logic       next_ld_out;
  logic       next_ld_oe_b;
  logic       next_ld_cur;
  logic       sel_ref_clk;
  logic       unsel_ref_clk;
  logic [6:0] ld_in_meta;
  logic [6:0] ld_in_sync;
  logic       alock_p_s;
  logic       alock_n_s;
  logic       ref1_clk_s;
  logic       ref2_clk_s;
  logic       ref2_sel_s;
  logic       ref1_ok_s;
  logic       ref2_ok_s;

  // analog lock and reference levels come from other domains: two flops before use
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ld_in_meta <= 7'h00;
      ld_in_sync <= 7'h00;
    end else begin
      ld_in_meta <= {analog_lock_p, analog_lock_n, ref1_clk, ref2_clk, ref2_selected, ref1_ok, ref2_ok};
      ld_in_sync <= ld_in_meta;
    end
  end

  assign {alock_p_s, alock_n_s, ref1_clk_s, ref2_clk_s, ref2_sel_s, ref1_ok_s, ref2_ok_s} = ld_in_sync;
  assign ld_sel        = act_stat_ld[LD_SEL_HI:LD_SEL_LO];
  assign sel_ref_clk   = ref2_sel_s ? ref2_clk_s : ref1_clk_s;
  assign unsel_ref_clk = ref2_sel_s ? ref1_clk_s : ref2_clk_s;

  always_comb begin
    next_ld_out  = 1'b0;
    next_ld_oe_b = 1'b0;
    next_ld_cur  = 1'b0;
    case (ld_sel)
      LD_DLD: begin
        next_ld_out = digital_lock_flag;
      end
      LD_PCH_OD: begin
        next_ld_out  = 1'b1;
        next_ld_oe_b = ~alock_p_s;
      end
      LD_NCH_OD: begin
        next_ld_out  = 1'b0;
        next_ld_oe_b = ~alock_n_s;
      end
      LD_HIZ: begin
        next_ld_oe_b = 1'b1;
      end
      LD_CUR: begin
        next_ld_oe_b = 1'b1;
        next_ld_cur  = digital_lock_flag;
      end
      LD_M_REF1:   next_ld_out = ref1_clk_s;
      LD_M_REF2:   next_ld_out = ref2_clk_s;
      LD_M_SEL:    next_ld_out = sel_ref_clk;
      LD_M_UNSEL:  next_ld_out = unsel_ref_clk;
      LD_M_SEL_OK: next_ld_out = ref2_sel_s ? ref2_ok_s : ref1_ok_s;
      LD_M_UNS_OK: next_ld_out = ref2_sel_s ? ref1_ok_s : ref2_ok_s;
      default: begin
        next_ld_out = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_indicator_pin_out  <= 1'b0;
      lock_indicator_pin_oe_b <= 1'b0;
      lock_indicator_cur_en   <= 1'b0;
    end else begin
      lock_indicator_pin_out  <= next_ld_out;
      lock_indicator_pin_oe_b <= next_ld_oe_b;
      lock_indicator_cur_en   <= next_ld_cur;
    end
  end

endmodule

// ---- bench/plc_monitor.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// port checker
// ---------------------------------------------------------------
module plc_monitor (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst_b,
  // watched ports
  input wire logic       io_update,
  input wire logic       digital_lock_flag,
  input wire logic       sync_pin_b,
  input wire logic       vco_cal_start,
  input wire logic       ctr_async_rst,
  input wire logic       ctr_sync_rst,
  input wire logic [2:0] ref_path_delay,
  input wire logic [2:0] fb_path_delay,
  input wire logic       lock_indicator_pin_oe_b,
  input wire logic       lock_indicator_cur_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_commit;
    $past(io_update, 2);
  endsequence
  property p_cal_cause; vco_cal_start |-> s_commit; endproperty
  a_cal_cause: assert property (p_cal_cause) else $error("cal start without update");
  property p_cal_once; vco_cal_start |=> !vco_cal_start; endproperty
  a_cal_once: assert property (p_cal_once) else $error("cal start too long");
  property p_sync_excl; !(ctr_async_rst && ctr_sync_rst); endproperty
  a_sync_excl: assert property (p_sync_excl) else $error("both counter resets");
  property p_async_cause; $rose(ctr_async_rst) |-> !$past(sync_pin_b, 3); endproperty
  a_async_cause: assert property (p_async_cause) else $error("async reset without sync");
  property p_sync_cause; $rose(ctr_sync_rst) |-> !$past(sync_pin_b, 3); endproperty
  a_sync_cause: assert property (p_sync_cause) else $error("sync reset without sync");
  property p_cur_lock; lock_indicator_cur_en |-> $past(digital_lock_flag); endproperty
  a_cur_lock: assert property (p_cur_lock) else $error("source on while unlocked");
  property p_cur_rel; lock_indicator_cur_en |-> lock_indicator_pin_oe_b; endproperty
  a_cur_rel: assert property (p_cur_rel) else $error("source with pin driven");
  property p_dly_upd; $changed({ref_path_delay, fb_path_delay}) |-> $past(io_update); endproperty
  a_dly_upd: assert property (p_dly_upd) else $error("delay changed without update");
endmodule
bind plc_top plc_monitor i_mon (.*);

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
  import plc_pkg::*;
  logic       core_clk, rst_b, reg_wr, reg_rd, io_update, sync_pin_b, vco_cal_start;
  logic       digital_lock_flag, analog_lock_p, analog_lock_n, ref1_clk, ref2_clk, ref2_selected;
  logic       ref1_ok, ref2_ok, ref_div_pulse, fb_div_pulse, ctr_async_rst, ctr_sync_rst;
  logic       ref_monitor_thresh, status_ref_div4, status_fb_div4;
  logic       lock_indicator_pin_out, lock_indicator_pin_oe_b, lock_indicator_cur_en;
  logic [9:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [6:0] lock_cal_cfg;
  logic [2:0] ref_path_delay, fb_path_delay, e;
  logic [7:0] m_act [3] = '{8'h06, 8'h00, 8'h00};
  logic [7:0] m_buf [3] = '{8'h06, 8'h00, 8'h00};
  logic [5:0] cd [16] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h1f, 6'h20,
                          6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27, 6'h3f};
  logic [15:0] lf = 16'hee70;
  int         fail_count = 0, check_count = 0, cyc = 0, ncal = 0, ntr = 0, ntf = 0;
  plc_top i_dut (.*);
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    ncal <= ncal + vco_cal_start;
    ntr <= ntr + $changed(status_ref_div4);
    ntf <= ntf + $changed(status_fb_div4);
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [2:0] lp(input logic [5:0] c);
    logic s;
    s = ref2_selected;
    case (c)
      LD_DLD:      return {digital_lock_flag, 2'b00};
      LD_PCH_OD:   return {1'b1, ~analog_lock_p, 1'b0};
      LD_NCH_OD:   return {1'b0, ~analog_lock_n, 1'b0};
      LD_HIZ:      return 3'b010;
      LD_CUR:      return {2'b01, digital_lock_flag};
      LD_M_REF1:   return {ref1_clk, 2'b00};
      LD_M_REF2:   return {ref2_clk, 2'b00};
      LD_M_SEL:    return {s ? ref2_clk : ref1_clk, 2'b00};
      LD_M_UNSEL:  return {s ? ref1_clk : ref2_clk, 2'b00};
      LD_M_SEL_OK: return {s ? ref2_ok : ref1_ok, 2'b00};
      LD_M_UNS_OK: return {s ? ref1_ok : ref2_ok, 2'b00};
      default:     return 3'b000;
    endcase
  endfunction
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    check_count++;
    if (g !== x) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge core_clk) reg_wr = 0;
    if (a >= 10'h018 && a <= 10'h01a) m_buf[a - 10'h018] = d;
    @(negedge core_clk);
  endtask
  task automatic upd();
    io_update = 1;
    @(negedge core_clk) io_update = 0;
    m_act = m_buf;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [9:0] a);
    reg_addr = a;
    reg_rd = 1;
    @(negedge core_clk) reg_rd = 0;
    chk("rdata", (a >= 10'h018 && a <= 10'h01a) ? m_act[a - 10'h018] : 8'h00, reg_rdata);
    @(negedge core_clk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, io_update, ref_div_pulse, fb_div_pulse} = '0;
    {digital_lock_flag, analog_lock_p, analog_lock_n, ref1_clk, ref2_clk} = '0;
    {ref2_selected, ref1_ok, ref2_ok, rst_b} = '0;
    sync_pin_b = 1;
    repeat (4) @(negedge core_clk);
    rst_b = 1;
    for (int i = 0; i < 4; i++) rd(i < 3 ? 10'h018 + i : 10'h100);
    wr(10'h019, lf[7:0]);
    wr(10'h100, 8'hff);
    rd(10'h019);
    upd();
    rd(10'h019);
    chk("delay", {2'b00, lf[5:0]}, {2'b00, ref_path_delay, fb_path_delay});
    // vco output divider lies outside this block and is left alone here
    wr(10'h018, 8'h5a);
    upd();
    wr(10'h018, 8'h5b);
    upd();
    repeat (3) @(negedge core_clk);
    chk("cal", 8'h01, ncal[7:0]);
    chk("calcfg", 8'h2d, {1'b0, lock_cal_cfg});
    upd();
    repeat (3) @(negedge core_clk);
    chk("cal", 8'h01, ncal[7:0]);
    for (int m = 0; m < 4; m++) begin
      wr(10'h019, 8'(m << 6));
      upd();
      sync_pin_b = 0;
      repeat (4) @(negedge core_clk);
      chk("ctrrst", {6'd0, m == 1, m == 2}, {6'd0, ctr_async_rst, ctr_sync_rst});
      sync_pin_b = 1;
      repeat (4) @(negedge core_clk);
      chk("ctrrst", 8'h00, {6'd0, ctr_async_rst, ctr_sync_rst});
    end
    for (int i = 0; i < 32; i++) begin
      wr(10'h01a, {1'b0, lf[8], cd[i / 2]});
      upd();
      {digital_lock_flag, analog_lock_p, analog_lock_n, ref1_clk} = lf[3:0];
      {ref2_clk, ref2_selected, ref1_ok, ref2_ok} = lf[7:4];
      lf = nx(lf);
      repeat (4) @(negedge core_clk);
      e = lp(cd[i / 2]);
      chk("ldpin", {5'd0, e}, {5'd0, lock_indicator_pin_out, lock_indicator_pin_oe_b,
          lock_indicator_cur_en});
      chk("thresh", {7'd0, m_act[2][REF_MON_THR]}, {7'd0, ref_monitor_thresh});
    end
    wr(10'h01a, 8'h80);
    upd();
    for (int i = 0; i < 8; i++) begin
      ref_div_pulse = 1;
      fb_div_pulse = i[0];
      @(negedge core_clk) {ref_div_pulse, fb_div_pulse} = '0;
      repeat (2) @(negedge core_clk);
    end
    chk("div4", 8'h42, {ntr[3:0], ntf[3:0]});
    wr(10'h01a, 8'h00);
    upd();
    repeat (3) @(negedge core_clk);
    chk("div4", 8'h00, {6'd0, status_ref_div4, status_fb_div4});
    conclude();
  end
endmodule
